// ==== verilog/ait_xlat.sv ====
// image address translator: register number to image word, framing, queues, capture
// assumes requests, bytes and the control word come from logic on core_clk,
// and the parity strap arrives from a pin
//
// Behaviour
// - registers 0.00 to 777.17 are single points
// - sixteen points packed per image word
// - point .00 sits in bit 0
// - discrete word index is number plus 64
// - integer word index is number minus 448
// - character is 10 bits, 11 with parity
// - at most three received requests wait
// - at most three local requests wait
// - at most three received responses wait
// - top bit marks response, two mark error
// - control bit 15 captures leading message bytes
`default_nettype none
module ait_xlat
  import ait_pkg::*;
#(
  parameter int QDEPTH = `AIT_Q_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // translation request and image access
  input wire ait_req_t req,
  output ait_img_t img,
  output logic xlat_ack,
  output logic xlat_err,
  // serial framing
  input wire logic parity_en,
  output logic [3:0] char_bits,
  // message queues: 0 received requests, 1 local requests, 2 received responses
  input wire logic [2:0] q_push,
  input wire logic [2:0] q_pop,
  output logic [2:0] q_full,
  output logic [2:0][$clog2(QDEPTH+1)-1:0] q_count,
  output logic [2:0] q_ovf,
  // command byte marking
  input wire logic cmd_in_vld,
  input wire logic [7:0] cmd_in,
  input wire ait_msg_kind_t cmd_kind,
  output logic cmd_vld,
  output logic [7:0] cmd_out,
  // message capture: 0 received, 1 transmitted
  input wire logic [15:0] ctrl_word,
  input wire ait_byte_t [1:0] msg_byte,
  output logic [1:0][4:0][15:0] dbg_words
);
  // whole state of the translator apart from the queue trackers
  typedef struct packed {
    ait_img_t img;
    logic ack;
    logic err;
    logic par_s1;
    logic par_s2;
    logic [3:0] char_bits;
    logic cmd_vld;
    logic [7:0] cmd_out;
    ait_cap_st_t [1:0] cap_st;
    logic [1:0][3:0] cap_cnt;
    logic [1:0][4:0][15:0] dbg;
  } ait_state_t;

  ait_state_t s_reg;
  ait_state_t s_next;
  ait_map_t map_w;   // translation of the current request
  logic dbg_on;      // capture enabled by the control word

  // range check and offset of one register number
  function automatic ait_map_t ait_map(input logic [11:0] num, input logic is_point);
    ait_map_t m;
    m = '0;
    if (num <= `AIT_DISC_LAST)
    begin
      m.ok = 1'b1;
      m.addr = num + `AIT_DISC_OFS;
    end
    // integer range, minus offset; points do not exist here
    else if (!is_point && num >= `AIT_INT_FIRST && num <= `AIT_INT_LAST)
    begin
      m.ok = 1'b1;
      m.addr = num - `AIT_INT_OFS;
    end
    return m;
  endfunction : ait_map

  // command byte with its response or error marks
  function automatic logic [7:0] ait_mark(input logic [7:0] c, input ait_msg_kind_t k);
    logic [7:0] r;
    r = c;
    case (k)
      AIT_MSG_RSP: r[`AIT_CMD_RSP_BIT] = 1'b1;
      AIT_MSG_ERR:
      begin
        r[`AIT_CMD_RSP_BIT] = 1'b1;
        r[`AIT_CMD_ERR_BIT] = 1'b1;
      end
      default: r = c;
    endcase
    return r;
  endfunction : ait_mark

  assign map_w = ait_map(req.reg_num, req.is_point);
  assign dbg_on = ctrl_word[`AIT_DBG_BIT];

  // outputs other than the queue ports come from the state register
  assign img = s_reg.img;
  assign xlat_ack = s_reg.ack;
  assign xlat_err = s_reg.err;
  assign char_bits = s_reg.char_bits;
  assign cmd_vld = s_reg.cmd_vld;
  assign cmd_out = s_reg.cmd_out;
  assign dbg_words = s_reg.dbg;

  // next state: translation, framing, marking and capture
  always_comb
  begin
    s_next = s_reg;
    s_next.img.en = 1'b0;
    s_next.ack = 1'b0;
    s_next.err = 1'b0;
    s_next.cmd_vld = 1'b0;
    // parity strap comes off a pin, so two flops before use
    s_next.par_s1 = parity_en;
    s_next.par_s2 = s_reg.par_s1;
    s_next.char_bits = s_reg.par_s2 ? `AIT_CHAR_BITS_PAR : `AIT_CHAR_BITS_NOPAR;
    // one answer per request, one cycle later
    if (req.vld)
    begin
      s_next.ack = 1'b1;
      s_next.err = !map_w.ok;
      s_next.img.en = map_w.ok;
      s_next.img.we = req.we;
      s_next.img.addr = map_w.addr;
      if (req.is_point)
      begin
        s_next.img.mask = `AIT_MASK_PT0 << req.point;
        s_next.img.wdata = req.wdata[0] ? s_next.img.mask : '0;
      end
      else
      begin
        s_next.img.mask = `AIT_MASK_WORD;
        s_next.img.wdata = req.wdata;
      end
    end
    if (cmd_in_vld)
    begin
      s_next.cmd_vld = 1'b1;
      s_next.cmd_out = ait_mark(cmd_in, cmd_kind);
    end
    // capture of leading bytes; first byte lands in the high half
    for (int ch = 0; ch < 2; ch++)
    begin
      if (!dbg_on)
        s_next.cap_st[ch] = AIT_CAP_IDLE;
      else if (msg_byte[ch].vld && msg_byte[ch].sof)
      begin
        s_next.dbg[ch] = '0;
        s_next.dbg[ch][0][15:8] = msg_byte[ch].data;
        s_next.cap_cnt[ch] = 4'h1;
        s_next.cap_st[ch] = AIT_CAP_RUN;
      end
      else if (msg_byte[ch].vld && s_reg.cap_st[ch] == AIT_CAP_RUN)
      begin
        if (s_reg.cap_cnt[ch][0])
          s_next.dbg[ch][s_reg.cap_cnt[ch][3:1]][7:0] = msg_byte[ch].data;
        else
          s_next.dbg[ch][s_reg.cap_cnt[ch][3:1]][15:8] = msg_byte[ch].data;
        s_next.cap_cnt[ch] = s_reg.cap_cnt[ch] + 4'h1;
        // later bytes of a long message are not kept
        if (s_reg.cap_cnt[ch] == `AIT_DBG_LAST_IDX)
          s_next.cap_st[ch] = AIT_CAP_IDLE;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.char_bits <= `AIT_CHAR_BITS_NOPAR;
    end
    else
      s_reg <= s_next;
  end

  generate
    for (genvar q = 0; q < 3; q++)
    begin : g_q
      ait_q_track #(
        .DEPTH(QDEPTH)
      ) u_q (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .push(q_push[q]),
        .pop(q_pop[q]),
        .full(q_full[q]),
        .count(q_count[q]),
        .overflow(q_ovf[q])
      );
    end
  endgenerate

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_disc_map;
    req.vld && req.reg_num <= `AIT_DISC_LAST
      |=> img.en && !xlat_err && img.addr == $past(req.reg_num) + `AIT_DISC_OFS;
  endproperty
  a_disc_map: assert property (p_disc_map) else $error("discrete word index wrong");

  property p_int_map;
    req.vld && !req.is_point && req.reg_num >= `AIT_INT_FIRST && req.reg_num <= `AIT_INT_LAST
      |=> img.en && img.addr == $past(req.reg_num) - `AIT_INT_OFS;
  endproperty
  a_int_map: assert property (p_int_map) else $error("integer word index wrong");

  property p_invalid;
    req.vld && !map_w.ok |=> xlat_ack && xlat_err && !img.en;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid number reached image");

  property p_pt0;
    req.vld && req.is_point && map_w.ok && req.point == 4'h0 |=> img.mask == `AIT_MASK_PT0;
  endproperty
  a_pt0: assert property (p_pt0) else $error("point 00 not in bit 0");

  property p_pt_mask;
    req.vld && req.is_point && map_w.ok |=> $onehot(img.mask) && img.mask[$past(req.point)];
  endproperty
  a_pt_mask: assert property (p_pt_mask) else $error("point mask wrong");

  property p_pt_range;
    req.vld && req.is_point && req.reg_num > `AIT_DISC_LAST |=> xlat_err;
  endproperty
  a_pt_range: assert property (p_pt_range) else $error("point outside discrete range");

  property p_char_par;
    parity_en [*3] |=> char_bits == `AIT_CHAR_BITS_PAR;
  endproperty
  a_char_par: assert property (p_char_par) else $error("parity character length wrong");

  property p_char_np;
    !parity_en [*3] |=> char_bits == `AIT_CHAR_BITS_NOPAR;
  endproperty
  a_char_np: assert property (p_char_np) else $error("plain character length wrong");

  property p_err_mark;
    cmd_in_vld && cmd_kind == AIT_MSG_ERR |=> cmd_vld && cmd_out[7:6] == 2'b11;
  endproperty
  a_err_mark: assert property (p_err_mark) else $error("error response not marked");

  property p_rsp_mark;
    cmd_in_vld && cmd_kind == AIT_MSG_RSP
      |=> cmd_out[7] && cmd_out[6:0] == $past(cmd_in[6:0]);
  endproperty
  a_rsp_mark: assert property (p_rsp_mark) else $error("response not marked");

  property p_q9;
    q_full[2] && q_push[2] && !q_pop[2] |=> q_ovf[2];
  endproperty
  a_q9: assert property (p_q9) else $error("response queue overrun unflagged");

  property p_dbg_first;
    dbg_on && msg_byte[0].vld && msg_byte[0].sof |=> dbg_words[0][0][15:8] == $past(msg_byte[0].data);
  endproperty
  a_dbg_first: assert property (p_dbg_first) else $error("first byte not captured");

  property p_dbg_off;
    !dbg_on |=> $stable(dbg_words);
  endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("capture while disabled");

  c_point_write: cover property (req.vld && req.we && req.is_point && map_w.ok ##1 img.en);
  c_int_read: cover property (req.vld && !req.we && req.reg_num >= `AIT_INT_FIRST ##1 img.en);
  c_invalid: cover property (req.vld && !map_w.ok ##1 xlat_err);
  c_q_full: cover property (q_full[0] && q_push[0] ##1 q_ovf[0]);
endmodule : ait_xlat
`default_nettype wire

// ==== common/ait_regs.svh ====
// image address translator: address map, framing and queue constants
// assumes inclusion by bare name from the package, compiled ahead of the design modules
`ifndef AIT_REGS_SVH
`define AIT_REGS_SVH

// last discrete register (777 octal), points packed sixteen to a word
`define AIT_DISC_LAST 12'h1ff
// word offset added to a discrete register number
`define AIT_DISC_OFS 12'h040
// integer registers run from 2000 octal to 6777 octal
`define AIT_INT_FIRST 12'h400
`define AIT_INT_LAST 12'hdff
// word offset subtracted from an integer register number
`define AIT_INT_OFS 12'h1c0
// whole-word and lowest-point masks of a packed word
`define AIT_MASK_WORD 16'hffff
`define AIT_MASK_PT0 16'h0001
// bit times per serial character without and with parity
`define AIT_CHAR_BITS_NOPAR 4'ha
`define AIT_CHAR_BITS_PAR 4'hb
// messages that may wait in each queue, the newest one included
`define AIT_Q_DEPTH 3
// control word bit that enables message capture
`define AIT_DBG_BIT 15
// leading bytes of a message kept for capture, and the last index
`define AIT_DBG_BYTES 10
`define AIT_DBG_LAST_IDX 4'h9
// command byte marks
`define AIT_CMD_RSP_BIT 7
`define AIT_CMD_ERR_BIT 6

`endif

// ==== common/ait_pkg.sv ====
// image address translator: shared types
// assumes the constants header sits beside this file
`default_nettype none
package ait_pkg;
  `include "ait_regs.svh"

  // one translation request from the rack side
  typedef struct packed {
    logic vld;           // request strobe
    logic we;            // write, else read
    logic is_point;      // single discrete point, else whole word
    logic [11:0] reg_num; // register number as the binary value of its octal form
    logic [3:0] point;   // point suffix .00 to .17
    logic [15:0] wdata;  // word data, bit 0 carries a point value
  } ait_req_t;

  // one access to the dual-port image
  typedef struct packed {
    logic en;
    logic we;
    logic [11:0] addr;
    logic [15:0] mask;
    logic [15:0] wdata;
  } ait_img_t;

  // one byte of a message on its way in or out
  typedef struct packed {
    logic vld;
    logic sof;
    logic [7:0] data;
  } ait_byte_t;

  // how a command byte is to be marked
  typedef enum logic [1:0] {
    AIT_MSG_REQ = 2'b00,
    AIT_MSG_RSP = 2'b01,
    AIT_MSG_ERR = 2'b10
  } ait_msg_kind_t;

  // capture state per direction
  typedef enum logic {
    AIT_CAP_IDLE = 1'b0,
    AIT_CAP_RUN = 1'b1
  } ait_cap_st_t;

  // translation result
  typedef struct packed {
    logic ok;
    logic [11:0] addr;
  } ait_map_t;
endpackage : ait_pkg
`default_nettype wire

// ==== verilog/ait_q_track.sv ====
// image address translator: occupancy tracker of one message queue
// assumes push and pop come from logic on core_clk
`default_nettype none
module ait_q_track
  import ait_pkg::*;
#(
  parameter int DEPTH = `AIT_Q_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // queue events
  input wire logic push,
  input wire logic pop,
  // occupancy
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic overflow
);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] MAXC = CW'(DEPTH);

  // whole state of the tracker
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ovf;
  } ait_q_state_t;

  ait_q_state_t s_reg;
  ait_q_state_t s_next;

  // full is combinational so a push in the same cycle sees it
  assign full = (s_reg.cnt == MAXC);
  assign count = s_reg.cnt;
  assign overflow = s_reg.ovf;

  // count moves by at most one; a push without a pop into a full queue is refused
  always_comb
  begin
    s_next = s_reg;
    s_next.ovf = 1'b0;
    if (push && !pop)
    begin
      if (full)
        s_next.ovf = 1'b1;
      else
        s_next.cnt = s_reg.cnt + CW'(1);
    end
    else if (pop && !push && s_reg.cnt != '0)
      s_next.cnt = s_reg.cnt - CW'(1);
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // an accepted push adds exactly one, so the count reaches the limit only by steps
  property p_q_max;
    push && !pop && !full |=> !overflow && count == $past(count) + CW'(1);
  endproperty
  a_q_max: assert property (p_q_max) else $error("accepted push not counted");

  property p_q_refuse;
    full && push && !pop |=> overflow && count == $past(count);
  endproperty
  a_q_refuse: assert property (p_q_refuse) else $error("push into full queue taken");
endmodule : ait_q_track
`default_nettype wire

// ==== testbench/ait_rack_model.sv ====
// rack side model: the dual-port image as the rack processor reads it
// assumes image accesses come from the translator on core_clk
`default_nettype none
module ait_rack_model
  import ait_pkg::*;
(
  // clock
  input wire logic core_clk,
  // image access from the translator
  input wire ait_img_t img,
  // word read by the rack
  input wire logic [11:0] rd_addr,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // image words; left unknown so a missed write shows up
  logic [15:0] mem [0:4095];
  // masked write keeps neighbouring points of a packed word
  always_ff @(posedge core_clk)
  begin
    if (img.en && img.we)
    begin
      mem[img.addr] <= (mem[img.addr] & ~img.mask) | (img.wdata & img.mask);
    end
  end
  // rack reads without delay
  assign rd_data = mem[rd_addr];
endmodule : ait_rack_model
`default_nettype wire

// ==== testbench/ait_xlat_test.sv ====
// translator bench: requests, framing, queues, command marks, capture
// assumes inputs change at the falling edge, outputs read there too
`default_nettype none
module ait_xlat_test
  import ait_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  ait_req_t req;
  ait_img_t img;
  logic xlat_ack, xlat_err, parity_en, cmd_in_vld, cmd_vld;
  logic [3:0] char_bits;
  logic [2:0] q_push, q_pop, q_full, q_ovf;
  logic [2:0][1:0] q_count;
  logic [7:0] cmd_in, cmd_out;
  ait_msg_kind_t cmd_kind;
  logic [15:0] ctrl_word, rd_data;
  ait_byte_t [1:0] msg_byte;
  logic [1:0][4:0][15:0] dbg_words;
  logic [11:0] rd_addr;
  int miscompares = 0;
  int total_checks = 0;
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  ait_xlat ait_xlat_i (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .img(img),
    .xlat_ack(xlat_ack), .xlat_err(xlat_err), .parity_en(parity_en),
    .char_bits(char_bits), .q_push(q_push), .q_pop(q_pop), .q_full(q_full),
    .q_count(q_count), .q_ovf(q_ovf), .cmd_in_vld(cmd_in_vld), .cmd_in(cmd_in),
    .cmd_kind(cmd_kind), .cmd_vld(cmd_vld), .cmd_out(cmd_out), .ctrl_word(ctrl_word),
    .msg_byte(msg_byte), .dbg_words(dbg_words));
  ait_rack_model ait_rack_model_i (.core_clk(core_clk), .img(img), .rd_addr(rd_addr),
    .rd_data(rd_data));
  // verdict and end of run
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // one compare for every kind of result, widened to a word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  // one write request; ok and ea are the expected verdict and word index
  task automatic xlat(input logic pt, input logic [11:0] rn, input logic [3:0] p,
    input logic ok, input logic [11:0] ea);
    logic [15:0] m;
    logic [15:0] wd;
    m = pt ? (16'h0001 << p) : 16'hffff;
    wd = pt ? m : 16'ha5c3;
    @(negedge core_clk);
    req <= '{vld: 1'b1, we: 1'b1, is_point: pt, reg_num: rn, point: p, wdata: pt ? 16'h0001 : wd};
    @(negedge core_clk);
    req.vld <= 1'b0;
    chk(16'(xlat_ack), 16'h0001);
    chk(16'(xlat_err), 16'(!ok));
    chk(16'(img.en), 16'(ok));
    if (ok)
    begin
      chk(16'(img.addr), 16'(ea));
      chk(img.mask, m);
      chk(16'(img.we), 16'h0001);
    end
    @(negedge core_clk);
    // answer lasts one cycle only
    chk(16'(xlat_ack), 16'h0000);
    if (ok)
    begin
      rd_addr = ea;
      #1;
      chk(rd_data & m, wd);
    end
  endtask : xlat
  // parity strap reaches the character length three cycles later
  task automatic framing();
    @(negedge core_clk);
    parity_en <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(16'(char_bits), 16'h000a);
    @(negedge core_clk);
    chk(16'(char_bits), 16'h000b);
    parity_en <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(16'(char_bits), 16'h000a);
  endtask : framing
  // fill a queue to three, push once more, then drain
  task automatic qfill(input int q);
    repeat (3)
    begin
      @(negedge core_clk);
      q_push[q] <= 1'b1;
    end
    @(negedge core_clk);
    chk(16'(q_count[q]), 16'h0003);
    chk(16'(q_full[q]), 16'h0001);
    @(negedge core_clk);
    q_push[q] <= 1'b0;
    chk(16'(q_ovf[q]), 16'h0001);
    chk(16'(q_count[q]), 16'h0003);
    repeat (3)
    begin
      @(negedge core_clk);
      q_pop[q] <= 1'b1;
    end
    @(negedge core_clk);
    q_pop[q] <= 1'b0;
    chk(16'(q_count[q]), 16'h0000);
  endtask : qfill
  // mark one command byte
  task automatic mark(input ait_msg_kind_t k, input logic [7:0] c, input logic [7:0] e);
    @(negedge core_clk);
    cmd_in_vld <= 1'b1;
    cmd_in <= c;
    cmd_kind <= k;
    @(negedge core_clk);
    cmd_in_vld <= 1'b0;
    chk(16'(cmd_vld), 16'h0001);
    chk(16'(cmd_out), 16'(e));
  endtask : mark
  // one message byte on a capture channel, strobe dropped by the caller
  task automatic send(input int ch, input logic s, input logic [7:0] d);
    @(negedge core_clk);
    msg_byte[ch] <= '{vld: 1'b1, sof: s, data: d};
  endtask : send
  // capture while enabled, keep contents while disabled, stop after ten bytes
  task automatic capture(input int ch);
    ctrl_word <= 16'h8000;
    send(ch, 1'b1, 8'h12);
    send(ch, 1'b0, 8'h34);
    send(ch, 1'b0, 8'h56);
    @(negedge core_clk);
    msg_byte[ch].vld <= 1'b0;
    chk(dbg_words[ch][0], 16'h1234);
    chk(dbg_words[ch][1], 16'h5600);
    ctrl_word <= 16'h7fff;
    send(ch, 1'b1, 8'h99);
    @(negedge core_clk);
    msg_byte[ch].vld <= 1'b0;
    @(negedge core_clk);
    chk(dbg_words[ch][0], 16'h1234);
    // eleven bytes: the tenth lands in the low half of the last word
    ctrl_word <= 16'h8000;
    send(ch, 1'b1, 8'h01);
    for (int b = 2; b <= 11; b++)
      send(ch, 1'b0, 8'(b));
    @(negedge core_clk);
    msg_byte[ch].vld <= 1'b0;
    chk(dbg_words[ch][0], 16'h0102);
    chk(dbg_words[ch][4], 16'h090a);
  endtask : capture
  // one word read of an integer register leaves the image as it was
  task automatic rdreq(input logic [11:0] rn, input logic [11:0] ea, input logic [15:0] keep);
    @(negedge core_clk);
    req <= '{vld: 1'b1, we: 1'b0, is_point: 1'b0, reg_num: rn, point: 4'h0, wdata: 16'h0000};
    @(negedge core_clk);
    req.vld <= 1'b0;
    chk(16'(xlat_err), 16'h0000);
    chk(16'(img.en), 16'h0001);
    chk(16'(img.we), 16'h0000);
    chk(16'(img.addr), 16'(ea));
    @(negedge core_clk);
    rd_addr = ea;
    #1;
    chk(rd_data, keep);
  endtask : rdreq
  // clearing one point keeps its neighbours in the packed word
  task automatic pclr(input logic [11:0] rn, input logic [3:0] p, input logic [11:0] ea,
    input logic [15:0] exp);
    @(negedge core_clk);
    req <= '{vld: 1'b1, we: 1'b1, is_point: 1'b1, reg_num: rn, point: p, wdata: 16'h0000};
    @(negedge core_clk);
    req.vld <= 1'b0;
    chk(img.wdata, 16'h0000);
    @(negedge core_clk);
    rd_addr = ea;
    #1;
    chk(rd_data, exp);
  endtask : pclr
  // reset in mid-run clears captured words, marks and counts
  task automatic midrst();
    @(negedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(dbg_words[0][0], 16'h0000);
    chk(16'(cmd_out), 16'h0000);
    chk(16'(q_count), 16'h0000);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(16'(char_bits), 16'h000a);
    chk(16'(xlat_ack), 16'h0000);
  endtask : midrst
  // a hang ends the run as a failure
  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    req = '0;
    parity_en = 1'b0;
    q_push = 3'h0;
    q_pop = 3'h0;
    cmd_in_vld = 1'b0;
    cmd_in = 8'h00;
    cmd_kind = AIT_MSG_REQ;
    ctrl_word = 16'h0000;
    msg_byte = '0;
    rd_addr = 12'h000;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(16'(char_bits), 16'h000a);
    chk(16'(q_count), 16'h0000);
    xlat(1'b1, 12'h05f, 4'h3, 1'b1, 12'h09f);
    xlat(1'b1, 12'h000, 4'h0, 1'b1, 12'h040);
    xlat(1'b1, 12'h1ff, 4'hf, 1'b1, 12'h23f);
    xlat(1'b0, 12'h05f, 4'h0, 1'b1, 12'h09f);
    pclr(12'h05f, 4'h0, 12'h09f, 16'ha5c2);
    xlat(1'b0, 12'h400, 4'h0, 1'b1, 12'h240);
    rdreq(12'h400, 12'h240, 16'ha5c3);
    xlat(1'b0, 12'hdff, 4'h0, 1'b1, 12'hc3f);
    xlat(1'b0, 12'h200, 4'h0, 1'b0, 12'h000);
    xlat(1'b0, 12'he00, 4'h0, 1'b0, 12'h000);
    xlat(1'b1, 12'h400, 4'h2, 1'b0, 12'h000);
    framing();
    qfill(0);
    qfill(1);
    qfill(2);
    mark(AIT_MSG_REQ, 8'h03, 8'h03);
    mark(AIT_MSG_RSP, 8'h03, 8'h83);
    mark(AIT_MSG_ERR, 8'h05, 8'hc5);
    capture(0);
    capture(1);
    midrst();
    end_of_test();
  end
endmodule : ait_xlat_test
`default_nettype wire
